// ==== rtl/brtw_top.sv ====
module brtw_top #(
   parameter int unsigned N_BAND       = brtw_pkg::N_BANDS,
   parameter int unsigned PULSE_CYC    = brtw_pkg::PULSE_CYCLES,
   parameter int unsigned DEF_BAND     = brtw_pkg::DEFAULT_BAND
) (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_freq_valid,
   input  wire logic [brtw_pkg::FREQ_W-1:0] i_freq_hz,
   input  wire logic [3:0]                  i_band,
   input  wire logic                        i_cal_toggle,
   input  wire logic                        i_cal_adj,
   input  wire logic                        i_cal_up,
   input  wire logic                        i_nv_load,
   input  wire logic [brtw_pkg::STEP_W-1:0] i_nv_step,
   output logic [brtw_pkg::FTW_W-1:0]       o_ftw,
   output logic                             o_ftw_valid,
   output logic [N_BAND-1:0]                o_relay,
   output logic                             o_relay_busy,
   output logic                             o_cal_active,
   output logic                             o_nv_wr,
   output logic [1:0]                       o_nv_index,
   output logic [7:0]                       o_nv_data,
   output logic [brtw_pkg::STEP_W-1:0]      o_step
);
   import brtw_pkg::*;

   localparam int unsigned IDX_W = (N_BAND > 1) ? $clog2(N_BAND) : 1;
   localparam logic [IDX_W-1:0] LAST_IDX = IDX_W'(N_BAND - 1);
   localparam logic [IDX_W-1:0] DEF_IDX  = IDX_W'(DEF_BAND);

   // ****************************************************************
   // Tuning word path
   // ****************************************************************
   logic                 freq_pend;
   logic [FREQ_W-1:0]    user_freq;
   logic                 mul_start;
   logic                 mul_busy;
   logic                 mul_done;
   logic [STEP_W-1:0]    mul_word;
   logic                 cal_begin;
   logic                 cal_end;
   logic                 cal_bump;
   logic [2:0]           nv_left;

   assign cal_begin = i_cal_toggle && !o_cal_active;
   assign cal_end   = i_cal_toggle && o_cal_active;
   assign cal_bump  = i_cal_adj && o_cal_active;

   // Calibration mode and the step constant; storage reloads only outside calibration.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_cal_active <= 1'b0;
         o_step       <= STEP_PRESET;
      end else begin
         if (i_cal_toggle) begin
            o_cal_active <= !o_cal_active;
         end
         if (cal_bump) begin
            // The smallest step keeps each encoder detent a fine trim.
            o_step <= i_cal_up ? o_step + CAL_STEP : o_step - CAL_STEP;
         end else if (i_nv_load && !o_cal_active) begin
            o_step <= i_nv_step;
         end
      end
   end

   // Latest user frequency; a retune is pending until the multiplier takes it.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         user_freq <= '0;
         freq_pend <= 1'b0;
         mul_start <= 1'b0;
      end else begin
         mul_start <= 1'b0;
         if (i_freq_valid) begin
            user_freq <= i_freq_hz;
         end
         if (freq_pend && !mul_busy && !mul_start) begin
            mul_start <= 1'b1;
            freq_pend <= 1'b0;
         end
         // A new request in the same cycle as the take wins, so none is lost.
         if (i_freq_valid || i_cal_toggle || cal_bump || i_nv_load) begin
            freq_pend <= 1'b1;
         end
      end
   end

   brtw_mul u_mul (
      .i_clk   (i_clk),
      .i_rst   (i_rst),
      .i_start (mul_start),
      .i_step  (o_step),
      .i_freq  (o_cal_active ? CAL_FREQ_HZ : user_freq),
      .o_busy  (mul_busy),
      .o_done  (mul_done),
      .o_word  (mul_word)
   );

   // The word goes out whole, product on top and zero padding below.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_ftw       <= '0;
         o_ftw_valid <= 1'b0;
      end else begin
         o_ftw_valid <= mul_done;
         if (mul_done) begin
            o_ftw <= {mul_word, {FTW_PAD_W{1'b0}}};
         end
      end
   end

   // ****************************************************************
   // Nonvolatile write-back
   // ****************************************************************
   // On leaving calibration the four bytes go out, index 3 first.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         nv_left    <= 3'h0;
         o_nv_wr    <= 1'b0;
         o_nv_index <= 2'h0;
         o_nv_data  <= 8'h0;
      end else begin
         o_nv_wr <= 1'b0;
         if (cal_end) begin
            nv_left <= 3'(NV_BYTES);
         end else if (nv_left != 3'h0) begin
            o_nv_wr    <= 1'b1;
            o_nv_index <= 2'(nv_left - 3'h1);
            o_nv_data  <= o_step[8*(nv_left - 3'h1) +: 8];
            nv_left    <= nv_left - 3'h1;
         end
      end
   end

   // ****************************************************************
   // Band relay sequencer
   // ****************************************************************
   brtw_state_e          state;
   logic [TIMER_W-1:0]   timer;
   logic                 known;
   logic [IDX_W-1:0]     last_set;
   logic [IDX_W-1:0]     set_idx;
   logic [IDX_W-1:0]     want;
   logic [IDX_W-1:0]     rst_idx;
   logic                 band_pend;
   logic                 band_take;
   logic [N_BAND-1:0]    one_hot_rst;
   logic [N_BAND-1:0]    one_hot_want;

   assign one_hot_rst  = N_BAND'(1) << rst_idx;
   assign one_hot_want = N_BAND'(1) << want;
   assign band_take    = (state == BRTW_IDLE) && band_pend;

   // Band requests ride on frequency requests; calibration leaves the relays alone.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         band_pend <= 1'b1;
         want      <= DEF_IDX;
      end else begin
         if (band_take) begin
            band_pend <= 1'b0;
         end
         if (i_freq_valid && !o_cal_active && (32'(i_band) < N_BAND)) begin
            want      <= i_band[IDX_W-1:0];
            band_pend <= 1'b1;
         end
      end
   end

   // Each pulse is preceded by a short phase with every line at the opposite level,
   // so the shared coil return sees a clean reversal.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         state        <= BRTW_IDLE;
         timer        <= '0;
         known        <= 1'b0;
         last_set     <= '0;
         set_idx      <= '0;
         rst_idx      <= '0;
         o_relay      <= '0;
         o_relay_busy <= 1'b0;
      end else begin
         if (timer != '0) begin
            timer <= timer - TIMER_W'(1);
         end
         unique case (state)
            BRTW_IDLE: begin
               o_relay      <= '0;
               o_relay_busy <= 1'b0;
               if (band_pend && (!known || want != last_set)) begin
                  rst_idx      <= known ? last_set : '0;
                  o_relay      <= '1;
                  o_relay_busy <= 1'b1;
                  timer        <= TIMER_W'(PREP_CYCLES - 1);
                  state        <= BRTW_RST_PREP;
               end
            end
            BRTW_RST_PREP: begin
               if (timer == '0) begin
                  o_relay <= ~one_hot_rst;
                  timer   <= TIMER_W'(PULSE_CYC - 1);
                  state   <= BRTW_RST_PULSE;
               end
            end
            BRTW_RST_PULSE: begin
               if (timer == '0) begin
                  timer <= TIMER_W'(PREP_CYCLES - 1);
                  if (!known && rst_idx != LAST_IDX) begin
                     rst_idx <= rst_idx + IDX_W'(1);
                     o_relay <= '1;
                     state   <= BRTW_RST_PREP;
                  end else begin
                     o_relay <= '0;
                     state   <= BRTW_SET_PREP;
                  end
               end
            end
            BRTW_SET_PREP: begin
               if (timer == '0) begin
                  // The pulsed index is latched, so a request during the pulse cannot
                  // make the record name a relay that was never set.
                  set_idx <= want;
                  o_relay <= one_hot_want;
                  timer   <= TIMER_W'(PULSE_CYC - 1);
                  state   <= BRTW_SET_PULSE;
               end
            end
            BRTW_SET_PULSE: begin
               if (timer == '0) begin
                  o_relay  <= '0;
                  last_set <= set_idx;
                  known    <= 1'b1;
                  state    <= BRTW_IDLE;
               end
            end
            default: begin
               o_relay <= '0;
               state   <= BRTW_IDLE;
            end
         endcase
      end
   end

endmodule

// ==== rtl/brtw_pkg.sv ====
package brtw_pkg;

   // ****************************************************************
   // Clock and timing
   // ****************************************************************
   localparam int unsigned CLK_HZ          = 40_000_000;
   localparam int unsigned PULSE_MS        = 8;
   localparam int unsigned PREP_NS         = 1000;
   // The pulse rounds down so it never runs long of its nominal length.
   localparam int unsigned PULSE_CYCLES    = (CLK_HZ / 1000) * PULSE_MS;
   // The preparation phase is a least time, so it rounds up.
   localparam int unsigned PREP_CYCLES     = (PREP_NS * (CLK_HZ / 1_000_000) + 999) / 1000;
   localparam int unsigned TIMER_W         = 24;

   // ****************************************************************
   // Tuning word layout
   // ****************************************************************
   localparam int unsigned STEP_W          = 32;
   localparam int unsigned FREQ_W          = 32;
   localparam int unsigned FTW_W           = 48;
   localparam int unsigned FTW_PAD_W       = 16;
   localparam int unsigned FRAC_BITS       = 24;
   localparam int unsigned MUL_CYCLES      = 32;
   localparam int unsigned NV_BYTES        = 4;

   // ****************************************************************
   // Presets and calibration
   // ****************************************************************
   localparam logic [31:0] STEP_PRESET     = 32'h225c17d0;
   localparam logic [31:0] CAL_FREQ_HZ     = 32'h0098_9680;
   localparam logic [31:0] CAL_STEP        = 32'h0000_0001;

   // ****************************************************************
   // Relay bank
   // ****************************************************************
   localparam int unsigned N_BANDS         = 9;
   localparam int unsigned DEFAULT_BAND    = 0;

   typedef enum logic [2:0] {
      BRTW_IDLE      = 3'h0,
      BRTW_RST_PREP  = 3'h1,
      BRTW_RST_PULSE = 3'h3,
      BRTW_SET_PREP  = 3'h2,
      BRTW_SET_PULSE = 3'h6
   } brtw_state_e;

endpackage

// ==== rtl/brtw_mul.sv ====
module brtw_mul (
   input  wire logic                        i_clk,
   input  wire logic                        i_rst,
   input  wire logic                        i_start,
   input  wire logic [brtw_pkg::STEP_W-1:0] i_step,
   input  wire logic [brtw_pkg::FREQ_W-1:0] i_freq,
   output logic                             o_busy,
   output logic                             o_done,
   output logic [brtw_pkg::STEP_W-1:0]      o_word
);
   import brtw_pkg::*;

   logic [63:0] acc;
   logic [63:0] mcand;
   logic [31:0] mplier;
   logic [5:0]  cnt;
   logic [63:0] next_acc;

   // One partial product per cycle keeps the adder to a single 64-bit stage.
   always_comb begin
      next_acc = mplier[0] ? acc + mcand : acc;
   end

   // Shift-and-add multiply; the integer part of step times frequency is kept.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         acc    <= 64'h0;
         mcand  <= 64'h0;
         mplier <= 32'h0;
         cnt    <= 6'h0;
         o_busy <= 1'b0;
         o_done <= 1'b0;
         o_word <= 32'h0;
      end else begin
         o_done <= 1'b0;
         if (i_start && !o_busy) begin
            acc    <= 64'h0;
            mcand  <= {32'h0, i_step};
            mplier <= i_freq;
            cnt    <= 6'(MUL_CYCLES);
            o_busy <= 1'b1;
         end else if (o_busy) begin
            acc    <= next_acc;
            mcand  <= {mcand[62:0], 1'b0};
            mplier <= {1'b0, mplier[31:1]};
            cnt    <= cnt - 6'h1;
            if (cnt == 6'h1) begin
               o_busy <= 1'b0;
               o_done <= 1'b1;
               o_word <= next_acc[FRAC_BITS +: STEP_W];
            end
         end
      end
   end

endmodule

// ==== testbench/brtw_top_asserts.sv ====
module brtw_top_asserts
   import brtw_pkg::*;
#(
   parameter int unsigned N_BAND    = brtw_pkg::N_BANDS,
   parameter int unsigned PULSE_CYC = brtw_pkg::PULSE_CYCLES
) (
   input wire logic                        i_clk,
   input wire logic                        i_rst,
   input wire logic [brtw_pkg::FTW_W-1:0]  o_ftw,
   input wire logic                        o_ftw_valid,
   input wire logic [N_BAND-1:0]           o_relay,
   input wire logic                        o_relay_busy,
   input wire logic                        o_cal_active,
   input wire logic                        o_nv_wr,
   input wire logic [1:0]                  o_nv_index,
   input wire logic [7:0]                  o_nv_data,
   input wire logic [brtw_pkg::STEP_W-1:0] o_step
);
   // ******************
   // Relay line history
   // ******************
   logic [N_BAND-1:0] prev;
   int unsigned       run;

   // Counts how many cycles the present relay pattern has stood.
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         prev <= '0;
         run  <= 0;
      end else begin
         prev <= o_relay;
         run  <= (o_relay != prev) ? 1 : run + 1;
      end
   end

   default clocking cb @(posedge i_clk); endclocking
   default disable iff (i_rst);

   property p_ftw_pad;
      o_ftw_valid |-> o_ftw[15:0] == 16'h0;
   endproperty
   a_ftw_pad: assert property (p_ftw_pad) else $error("tuning word pad not zero");
   property p_shape;
      $onehot0(o_relay) || $onehot(~o_relay) || &o_relay;
   endproperty
   a_shape: assert property (p_shape) else $error("illegal relay pattern");
   property p_set_prep;
      $onehot(o_relay) && o_relay != prev |-> prev == '0;
   endproperty
   a_set_prep: assert property (p_set_prep) else $error("set without all low");
   property p_rst_prep;
      $onehot(~o_relay) && o_relay != prev |-> &prev;
   endproperty
   a_rst_prep: assert property (p_rst_prep) else $error("reset without all high");
   property p_pulse_len;
      o_relay != prev && ($onehot(prev) || $onehot(~prev)) |-> run == PULSE_CYC;
   endproperty
   a_pulse_len: assert property (p_pulse_len) else $error("pulse length wrong");
   property p_idle;
      !o_relay_busy |-> o_relay == '0;
   endproperty
   a_idle: assert property (p_idle) else $error("relay lines not idle");
   property p_nv_start;
      $fell(o_cal_active) |=> o_nv_wr && o_nv_index == 2'h3;
   endproperty
   a_nv_start: assert property (p_nv_start) else $error("no store on exit");
   property p_nv_data;
      o_nv_wr |-> o_nv_data == o_step[8*o_nv_index +: 8];
   endproperty
   a_nv_data: assert property (p_nv_data) else $error("stored byte wrong");
endmodule

bind brtw_top brtw_top_asserts #(.N_BAND(N_BAND), .PULSE_CYC(PULSE_CYC)) chk (
   .i_clk(i_clk), .i_rst(i_rst), .o_ftw(o_ftw), .o_ftw_valid(o_ftw_valid),
   .o_relay(o_relay), .o_relay_busy(o_relay_busy), .o_cal_active(o_cal_active),
   .o_nv_wr(o_nv_wr), .o_nv_index(o_nv_index), .o_nv_data(o_nv_data), .o_step(o_step)
);

// ==== testbench/brtw_far_model.sv ====
module brtw_far_model #(
   parameter int unsigned N_BAND = 9
) (
   input wire logic                       i_clk,
   input wire logic [N_BAND-1:0]          i_relay,
   input wire logic [brtw_pkg::FTW_W-1:0] i_ftw,
   input wire logic                       i_ftw_valid
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [N_BAND-1:0] prev = '0;
   logic [47:0]       ftw = '0;
   int                n_ftw = 0;
   int                ev[$];

   // A coil moves only when one line stands apart from all others.
   always @(posedge i_clk) begin
      prev <= i_relay;
      if (i_relay != prev && $onehot(i_relay)) begin
         ev.push_back($clog2(i_relay));
      end
      if (i_relay != prev && $onehot(~i_relay)) begin
         ev.push_back(16 + $clog2(~i_relay));
      end
      if (i_ftw_valid === 1'b1) begin
         ftw <= i_ftw;
         n_ftw <= n_ftw + 1;
      end
   end
endmodule

// ==== testbench/testbench.sv ====
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   import brtw_pkg::*;
   localparam int unsigned PC = 50;
   logic                  i_clk = 1'b0, i_rst = 1'b1;
   logic                  fv = 1'b0, ctog = 1'b0, cadj = 1'b0, cup = 1'b0, nvl = 1'b0;
   logic [3:0]            band = 4'hf;
   logic [31:0]           fhz = '0, nvs = '0, s, f, fu, step;
   logic [47:0]           ftw;
   logic [N_BANDS-1:0]    relay;
   logic                  fval, busy, cal, nvw;
   logic [1:0]            nvi;
   logic [7:0]            nvd, nvb [4];
   int                    fails = 0, n_checks = 0, cyc = 0, nf;

   brtw_top #(.PULSE_CYC(PC)) uut (
      .i_clk(i_clk), .i_rst(i_rst), .i_freq_valid(fv), .i_freq_hz(fhz), .i_band(band),
      .i_cal_toggle(ctog), .i_cal_adj(cadj), .i_cal_up(cup), .i_nv_load(nvl),
      .i_nv_step(nvs), .o_ftw(ftw), .o_ftw_valid(fval), .o_relay(relay),
      .o_relay_busy(busy), .o_cal_active(cal), .o_nv_wr(nvw), .o_nv_index(nvi),
      .o_nv_data(nvd), .o_step(step)
   );
   brtw_far_model far (.i_clk(i_clk), .i_relay(relay), .i_ftw(ftw), .i_ftw_valid(fval));

   // Clock and hang guard; the run needs about three thousand cycles.
   initial begin
      forever #12.5 i_clk = ~i_clk;
   end
   always @(posedge i_clk) begin
      cyc <= cyc + 1;
      if (cyc == 8000) begin
         fails++;
         end_sim();
      end
   end
   // Collects the bytes sent to storage by index.
   always @(posedge i_clk) begin
      if (nvw === 1'b1) nvb[nvi] <= nvd;
   end

   function automatic logic [47:0] exp_ftw(input logic [31:0] k, input logic [31:0] hz);
      logic [63:0] p;
      p = {32'h0, k} * {32'h0, hz};
      return {p[55:24], 16'h0};
   endfunction

   task automatic chk(input logic [47:0] got, input logic [47:0] exp, input string m);
      n_checks++;
      if (got !== exp) begin
         fails++;
         $display("BAD %0t %s got %h exp %h", $time, m, got, exp);
      end
   endtask

   // One-cycle request: 0 frequency, 1 calibrate, 2 adjust, 3 storage load.
   task automatic strobe(input int w, input logic [3:0] b, input logic [31:0] v);
      nf = far.n_ftw;
      @(posedge i_clk);
      case (w)
         0: fv <= 1'b1;
         1: ctog <= 1'b1;
         2: cadj <= 1'b1;
         default: nvl <= 1'b1;
      endcase
      fhz <= v;
      nvs <= v;
      band <= b;
      @(posedge i_clk);
      {fv, ctog, cadj, nvl} <= 4'h0;
   endtask

   // Waits for a new word and then for 40 quiet cycles, so that retunes
   // collapsed behind a busy multiplier have all come out.
   task automatic wait_ftw();
      int seen;
      int q;
      seen = nf;
      q = 0;
      for (int k = 0; k < 300 && (far.n_ftw == nf || q < 40); k++) begin
         @(posedge i_clk);
         q = (far.n_ftw == seen) ? q + 1 : 0;
         seen = far.n_ftw;
      end
      if (far.n_ftw == nf) begin
         fails++;
         $display("BAD %0t no tuning word came", $time);
      end
   endtask

   task automatic wait_idle();
      repeat (3) @(posedge i_clk);
      for (int k = 0; k < 3000 && busy !== 1'b0; k++) @(posedge i_clk);
      if (busy !== 1'b0) begin
         fails++;
         $display("BAD %0t relay sequence did not finish", $time);
      end
   endtask

   task automatic end_sim();
      $display("checks %0d mismatches %0d", n_checks, fails);
      if (fails == 0 && n_checks > 0) begin
         $display("verification passed");
      end else begin
         $display("verification failed");
      end
      $finish;
   endtask

   // Main sequence: sweep, band change, random words, calibration.
   initial begin
      void'($urandom(32'h59fa));
      repeat (20) @(posedge i_clk);
      chk(48'(step), 48'(STEP_PRESET), "preset");
      i_rst <= 1'b0;
      wait_idle();
      chk(48'(far.ev.size()), 48'd10, "sweep count");
      for (int i = 0; i < 10; i++) begin
         chk(48'(far.ev[i]), (i < 9) ? 48'(16 + i) : 48'(DEFAULT_BAND), "sweep");
      end
      $display("test power-on sweep done");
      fu = 32'd7_040_000;
      strobe(0, 4'h3, fu);
      wait_idle();
      chk(48'(far.ev[10]), 48'(16 + DEFAULT_BAND), "old relay reset");
      chk(48'(far.ev[11]), 48'd3, "new relay set");
      chk(far.ftw, exp_ftw(STEP_PRESET, fu), "ftw");
      fu = fu + 1;
      strobe(0, 4'h3, fu);
      wait_ftw();
      chk(48'(far.ev.size()), 48'd12, "same band");
      chk(far.ftw, exp_ftw(STEP_PRESET, fu), "ftw");
      $display("test band change done");
      for (int i = 0; i < 8; i++) begin
         s = (i == 0) ? STEP_PRESET : $urandom();
         f = (i == 1) ? '1 : (i == 2) ? '0 : $urandom_range(30_000_000);
         strobe(3, 4'hf, s);
         wait_ftw();
         chk(48'(step), 48'(s), "load");
         chk(far.ftw, exp_ftw(s, fu), "reload");
         strobe(0, 4'hf, f);
         wait_ftw();
         chk(far.ftw, exp_ftw(s, f), "ftw");
         fu = f;
      end
      $display("test tuning words done");
      fu = f;
      strobe(1, 4'hf, fu);
      wait_ftw();
      chk(48'(cal), 48'd1, "cal on");
      chk(far.ftw, exp_ftw(s, CAL_FREQ_HZ), "cal tune");
      cup <= 1'b1;
      repeat (3) strobe(2, 4'hf, fu);
      cup <= 1'b0;
      strobe(2, 4'hf, fu);
      wait_ftw();
      s = s + 2 * CAL_STEP;
      chk(48'(step), 48'(s), "cal step");
      strobe(0, 4'h5, fu);
      wait_ftw();
      chk(48'(far.ev.size()), 48'd12, "cal band");
      chk(far.ftw, exp_ftw(s, CAL_FREQ_HZ), "cal retune");
      strobe(1, 4'hf, fu);
      wait_ftw();
      chk(48'({nvb[3], nvb[2], nvb[1], nvb[0]}), 48'(s), "saved");
      chk(far.ftw, exp_ftw(s, fu), "after cal");
      chk(48'(cal), 48'd0, "cal off");
      $display("test calibration done");
      end_sim();
   end
endmodule
